// File: verilog/ltc_control.sv
// What this block does
// - Repeat only when trigger and repeat set
// - No repeating while in power save
// - Codes 0..8 route LED one to nine
// - Codes 0F, 10, 11: pump, battery, pin
// - Result at 0x42, read only
// - Result step 30 mV, offset 1.478 V
// - Writing trigger one starts one 2.7 ms conversion
// - Done raises interrupt when IRQ enable (bit 6) is set; status read clears it
`timescale 1ns/1ps
module ltc_control
    import ltc_pkg::*;
#(
    parameter int CONV_CYCLES_P = CONV_CYCLES
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // Register port from the serial bus slave
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wr_data_i,
    output logic      [7:0] rd_data_o,
    // Device mode
    input  wire logic       power_save_i,
    // Analog converter
    input  wire logic [7:0] adc_code_i,
    output logic      [4:0] chan_sel_o,
    output ltc_route_t      route_o,
    output logic            conv_busy_o,
    // Completion
    output logic            done_flag_o,
    output logic            irq_o
);

    ltc_state_t st_ff;
    ltc_state_t nxt_st;
    ltc_route_t route_dec;
    logic       conv_done;
    logic       start_req;
    logic       repeat_ok;
    logic       status_rd;

    // Per-LED mux decode from the channel field
    // LED routing
    for (genvar g = 0; g < NUM_LEDS; g++) begin : g_led
        assign route_dec.led[g] = (st_ff.ctrl[CHAN_MSB:0] == 5'(g));
    end
    assign route_dec.pump   = (st_ff.ctrl[CHAN_MSB:0] == CH_PUMP);
    assign route_dec.batt   = (st_ff.ctrl[CHAN_MSB:0] == CH_BATT);
    assign route_dec.irqpin = (st_ff.ctrl[CHAN_MSB:0] == CH_IRQPIN);
    // Reserved codes leave the mux open

    // Sequencer conditions
    assign conv_done = (st_ff.fsm == ST_CONV) &&
                       (st_ff.timer == TIMER_W'(CONV_CYCLES_P - 1));
    // Write of one fires a conversion
    assign start_req = wr_en_i && (addr_i == ADDR_CTRL) && wr_data_i[TRIG_BIT];
    assign repeat_ok = st_ff.ctrl[TRIG_BIT] && st_ff.ctrl[REPEAT_BIT] && !power_save_i;
    assign status_rd = rd_en_i && (addr_i == ADDR_STATUS);

    // Next-state logic for the whole block
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.sync1 = adc_code_i;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.route = route_dec;

        // Control register; result register ignores writes
        // Result is read only
        if (wr_en_i && (addr_i == ADDR_CTRL)) begin
            nxt_st.ctrl = wr_data_i;
        end

        // Read port, unmapped and status offsets answer zero
        if (rd_en_i) begin
            unique case (addr_i)
                ADDR_CTRL:   nxt_st.rd_data = st_ff.ctrl;
                ADDR_RESULT: nxt_st.rd_data = st_ff.result;
                default:     nxt_st.rd_data = 8'h00;
            endcase
        end

        // Status read clears; a same-cycle completion wins below
        if (status_rd) begin
            nxt_st.irq       = 1'b0;
            nxt_st.done_flag = 1'b0;
        end

        unique case (st_ff.fsm)
            ST_IDLE: begin
                nxt_st.timer = '0;
                // Resume repeating once power save ends
                if (start_req || repeat_ok) begin
                    nxt_st.fsm = ST_CONV;
                end
            end
            ST_CONV: begin
                nxt_st.timer = st_ff.timer + TIMER_W'(1);
                if (conv_done) begin
                    // Code scales by 30 mV, less 1.478 V
                    nxt_st.result    = st_ff.sync2;
                    nxt_st.done_flag = 1'b1;
                    nxt_st.timer     = '0;
                    if (st_ff.ctrl[IRQEN_BIT]) begin
                        nxt_st.irq = 1'b1;
                    end
                    nxt_st.fsm = repeat_ok ? ST_CONV : ST_IDLE;
                end
            end
            default: begin
                nxt_st.fsm   = ST_IDLE;
                nxt_st.timer = '0;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_ff.fsm       <= ST_IDLE;
            st_ff.timer     <= '0;
            st_ff.ctrl      <= CTRL_RESET;
            st_ff.result    <= RESULT_RESET;
            st_ff.rd_data   <= 8'h00;
            st_ff.irq       <= 1'b0;
            st_ff.done_flag <= 1'b0;
            st_ff.sync1     <= 8'h00;
            st_ff.sync2     <= 8'h00;
            st_ff.route     <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flops
    assign rd_data_o   = st_ff.rd_data;
    assign chan_sel_o  = st_ff.ctrl[CHAN_MSB:0];
    assign route_o     = st_ff.route;
    assign conv_busy_o = st_ff.fsm[1];
    assign done_flag_o = st_ff.done_flag;
    assign irq_o       = st_ff.irq;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    AST_RESULT_RO: assert property (
        (wr_en_i && addr_i == ADDR_RESULT && !conv_done) |=> $stable(st_ff.result))
        else $error("result changed by host write");
    AST_RESULT_HOLD: assert property (
        !conv_done |=> $stable(st_ff.result))
        else $error("result changed without a completion");
    AST_RESULT_READ: assert property (
        (rd_en_i && addr_i == ADDR_RESULT) |=> rd_data_o == $past(st_ff.result))
        else $error("result read returned wrong data");
    AST_SINGLE_START: assert property (
        (st_ff.fsm == ST_IDLE && start_req) |=> conv_busy_o && st_ff.timer == '0)
        else $error("trigger write did not start conversion");
    AST_CONV_LENGTH: assert property (
        conv_busy_o |-> st_ff.timer < TIMER_W'(CONV_CYCLES_P))
        else $error("conversion ran past its time");
    AST_BUSY_STEP: assert property (
        (conv_busy_o && !conv_done) |=>
            conv_busy_o && st_ff.timer == $past(st_ff.timer) + TIMER_W'(1))
        else $error("running conversion restarted or stalled");
    AST_NO_SELF_START: assert property (
        (!conv_busy_o && !start_req && !repeat_ok) |=> !conv_busy_o)
        else $error("conversion started without a trigger");
    AST_IRQ_ON_DONE: assert property (
        (conv_done && st_ff.ctrl[IRQEN_BIT]) |=> irq_o && done_flag_o)
        else $error("completion did not raise interrupt");
    AST_IRQ_CLEAR: assert property (
        (status_rd && !conv_done) |=> !irq_o ##1 (!irq_o || $past(conv_done)))
        else $error("status read did not clear interrupt");
    AST_NO_IRQ_MASKED: assert property (
        (!irq_o && !(conv_done && st_ff.ctrl[IRQEN_BIT])) |=> !irq_o)
        else $error("interrupt without enabled completion");
    AST_REPEAT: assert property (
        (conv_done && repeat_ok) |=> conv_busy_o && st_ff.result == $past(st_ff.sync2))
        else $error("continuous mode did not restart");
    AST_RESULT_CAPTURE: assert property (
        conv_done |=> st_ff.result == $past(st_ff.sync2) && done_flag_o)
        else $error("completion did not capture result");
    AST_NO_REPEAT: assert property (
        (conv_done && !st_ff.ctrl[REPEAT_BIT]) |=> !conv_busy_o)
        else $error("single conversion repeated");
    AST_PS_HOLD: assert property (
        (!conv_busy_o && power_save_i && !start_req) |=> !conv_busy_o)
        else $error("conversion started in power save");
    AST_PS_STOP: assert property (
        (conv_done && power_save_i) |=> !conv_busy_o)
        else $error("repeat continued in power save");
    AST_CTRL_WRITE: assert property (
        (wr_en_i && addr_i == ADDR_CTRL) |=> 8'(chan_sel_o) == ($past(wr_data_i) & 8'h1F))
        else $error("channel field not updated by write");
    AST_ROUTE_LED: assert property (
        (chan_sel_o <= CH_LED_LAST && !wr_en_i) |=> route_o.led == (9'h001 << chan_sel_o))
        else $error("LED routing wrong");
    AST_ROUTE_PUMP: assert property (
        (chan_sel_o == CH_PUMP && !wr_en_i) |=> route_o.pump && route_o.led == '0)
        else $error("pump routing wrong");
    AST_ROUTE_BATT: assert property (
        (chan_sel_o == CH_BATT && !wr_en_i) |=>
            route_o.batt && !route_o.pump && !route_o.irqpin && route_o.led == '0)
        else $error("battery routing wrong");
    AST_ROUTE_IRQPIN: assert property (
        (chan_sel_o == CH_IRQPIN && !wr_en_i) |=>
            route_o.irqpin && !route_o.pump && !route_o.batt && route_o.led == '0)
        else $error("interrupt pin routing wrong");

    COV_SINGLE: cover property (start_req ##1 conv_busy_o);
    COV_IRQ: cover property (conv_done && st_ff.ctrl[IRQEN_BIT] ##1 irq_o);
    COV_REPEAT: cover property (conv_done && repeat_ok);
    COV_CLEAR_RACE: cover property (status_rd && conv_done);

endmodule // ltc_control

// File: verilog/ltc_pkg.sv
package ltc_pkg;

    // Register offsets on the serial control port
    localparam logic [7:0] ADDR_CTRL     = 8'h41;
    localparam logic [7:0] ADDR_RESULT   = 8'h42;
    localparam logic [7:0] ADDR_STATUS   = 8'h3A;

    // Control register field positions
    localparam int         TRIG_BIT      = 7;
    localparam int         IRQEN_BIT     = 6;
    localparam int         REPEAT_BIT    = 5;
    localparam int         CHAN_MSB      = 4;

    // Reset values
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] RESULT_RESET  = 8'h00;

    // Channel codes
    localparam logic [4:0] CH_LED_LAST   = 5'h08;
    localparam logic [4:0] CH_PUMP       = 5'h0F;
    localparam logic [4:0] CH_BATT       = 5'h10;
    localparam logic [4:0] CH_IRQPIN     = 5'h11;
    localparam int         NUM_LEDS      = 9;

    // Result scaling: volts = code * LSB - offset
    localparam int         RESULT_LSB_MV = 30;
    localparam int         OFFSET_MV     = 1478;

    // Conversion time, 2.7 ms at the 100 MHz core clock
    localparam int         CONV_TIME_US  = 2700;
    localparam int         CLK_MHZ       = 100;
    localparam int         CONV_CYCLES   = CONV_TIME_US * CLK_MHZ;
    localparam int         TIMER_W       = 19;

    // Converter sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } ltc_fsm_t;

    // Analog mux routing, one bit per source
    typedef struct packed {
        logic [NUM_LEDS-1:0] led;
        logic                pump;
        logic                batt;
        logic                irqpin;
    } ltc_route_t;

    // Whole block state
    typedef struct packed {
        ltc_fsm_t             fsm;
        logic [TIMER_W-1:0]   timer;
        logic [7:0]           ctrl;
        logic [7:0]           result;
        logic [7:0]           rd_data;
        logic                 irq;
        logic                 done_flag;
        logic [7:0]           sync1;
        logic [7:0]           sync2;
        ltc_route_t           route;
    } ltc_state_t;

endpackage

// File: dv/ltc_adc_model.sv
`timescale 1ns/1ps
module ltc_adc_model
    import ltc_pkg::*;
(
    // Mux routing from the block
    input  wire ltc_route_t route_i,
    // Converter code back to the block
    output logic [7:0]      code_o
);
    // Code names the routed source; no source gives junk so stale codes show
    always_comb begin
        code_o = 8'hEE;
        for (int i = 0; i < 12; i++) begin
            if (route_i[i]) begin
                code_o = 8'h40 + 8'(i);
            end
        end
    end
endmodule // ltc_adc_model

// File: dv/tb_ltc_control.sv
`timescale 1ns/1ps
module tb_ltc_control;
    import ltc_pkg::*;
    localparam int CONV_P = 20;
    logic       clk_i        = 1'b0;
    logic       sys_rst_i    = 1'b1;
    logic       wr_en_i      = 1'b0;
    logic       rd_en_i      = 1'b0;
    logic [7:0] addr_i       = 8'h00;
    logic [7:0] wr_data_i    = 8'h00;
    logic       power_save_i = 1'b0;
    logic [7:0] rd_data_o;
    logic [7:0] adc_code_i;
    logic [4:0] chan_sel_o;
    ltc_route_t route_o;
    logic       conv_busy_o;
    logic       done_flag_o;
    logic       irq_o;
    int         failures        = 0;
    int         samples_checked = 0;
    int         cycles          = 0;
    int         n;

    ltc_control #(.CONV_CYCLES_P(CONV_P)) ltc_control_inst (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .power_save_i(power_save_i),
        .adc_code_i(adc_code_i), .chan_sel_o(chan_sel_o), .route_o(route_o),
        .conv_busy_o(conv_busy_o), .done_flag_o(done_flag_o), .irq_o(irq_o));
    ltc_adc_model ltc_adc_model_inst (.route_i(route_o), .code_o(adc_code_i));

    // Clock and hang guard
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2500) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register port: one-cycle strobes launched on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr_en_i = 1'b1;
        addr_i = a;
        wr_data_i = d;
        @(negedge clk_i);
        wr_en_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_i);
        rd_en_i = 1'b1;
        addr_i = a;
        @(negedge clk_i);
        rd_en_i = 1'b0;
        chk(12'(rd_data_o), 12'(exp));
    endtask

    // Bounded waits on the busy level; n ends as cycles spent busy
    task automatic idle();
        n = 0;
        while (conv_busy_o !== 1'b0 && n < 60) begin
            @(negedge clk_i);
            n++;
        end
    endtask

    task automatic conv(input int len);
        n = 0;
        while (conv_busy_o !== 1'b1 && n < 10) begin
            @(negedge clk_i);
            n++;
        end
        idle();
        chk(12'(n), 12'(len));
    endtask

    // One-hot mux enable expected for a channel code
    function automatic logic [11:0] exp_route(input logic [4:0] c);
        if (c <= CH_LED_LAST) return 12'h008 << c;
        if (c == CH_PUMP) return 12'h004;
        if (c == CH_BATT) return 12'h002;
        if (c == CH_IRQPIN) return 12'h001;
        return 12'h000;
    endfunction

    initial begin
        repeat (12) @(negedge clk_i);
        sys_rst_i = 1'b0;
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_RESULT, RESULT_RESET);
        // Every legal code: field on the pins, mux one cycle later
        for (int c = 0; c < 32; c++) begin
            if ((5'(c) > CH_LED_LAST && 5'(c) < CH_PUMP) || 5'(c) > CH_IRQPIN) continue;
            wr(ADDR_CTRL, 8'(c));
            chk(12'(chan_sel_o), 12'(c));
            @(negedge clk_i);
            chk(route_o, exp_route(5'(c)));
        end
        $display("Test reset and routing done");
        wr(ADDR_CTRL, 8'h84);
        conv(CONV_P);
        rd(ADDR_RESULT, 8'h47);
        chk(12'({done_flag_o, irq_o}), 12'h002);
        repeat (5) @(negedge clk_i);
        chk(12'(conv_busy_o), 12'h000);
        wr(ADDR_RESULT, 8'h55);
        rd(ADDR_RESULT, 8'h47);
        rd(ADDR_STATUS, 8'h00);
        chk(12'(done_flag_o), 12'h000);
        wr(ADDR_CTRL, 8'hD0);
        conv(CONV_P);
        chk(12'(irq_o), 12'h001);
        rd(ADDR_RESULT, 8'h41);
        rd(ADDR_STATUS, 8'h00);
        chk(12'(irq_o), 12'h000);
        $display("Test single conversion done");
        // Busy must never drop between repeated conversions
        wr(ADDR_CTRL, 8'hAF);
        n = 0;
        repeat (70) begin
            @(negedge clk_i);
            n += conv_busy_o ? 0 : 1;
        end
        chk(12'(n), 12'h000);
        rd(ADDR_CTRL, 8'hAF);
        rd(ADDR_RESULT, 8'h42);
        wr(ADDR_CTRL, 8'hB0);
        repeat (45) @(negedge clk_i);
        rd(ADDR_RESULT, 8'h41);
        power_save_i = 1'b1;
        idle();
        repeat (45) @(negedge clk_i);
        chk(12'(conv_busy_o), 12'h000);
        power_save_i = 1'b0;
        repeat (3) @(negedge clk_i);
        chk(12'(conv_busy_o), 12'h001);
        wr(ADDR_CTRL, 8'h00);
        idle();
        $display("Test continuous done");
        report_and_stop();
    end
endmodule // tb_ltc_control
